// File: ipl_ctrl.sv
// six shared pins: general purpose io with level irq, or port status leds
`timescale 1ns/1ps

// Behaviour
// - six pins, each input, push-pull or open-drain output, each may interrupt
// - reset clears every direction bit, all pins inputs
// - reset clears all six interrupt enable bits
// - reset clears all polarity bits, low level triggers
// - buffer type bit picks push-pull or open-drain for outputs
// - open-drain drives low for data 0, releases pin for data 1
// - push-pull drives the data bit value
// - data bit reads back live pin level for input pins
// - per-pin readable status bit and enable bit; enable gates effect
// - enabled statuses merge into one request, mirrored in system status
// - polarity 1 sets status on high level, 0 on low level
// - led enable makes pin an led output, input buffer off
// - two-bit function field; field and led enables reset from straps
// - codes 0-2: active drives opposite latched polarity strap, else undriven
// - port 0 transmit shows 80 ms pulse then at least 80 ms off
// - port 0 receive shows 80 ms pulse then at least 80 ms off
// - link/activity active on link, 80 ms off on activity, 80 ms on
// - duplex/collision on in full duplex, 80 ms collision pulses, off no link
// - speed on for 100 Mbps link, off for 10 Mbps or no link
// - speed-qualified link/activity behaves like link/activity at own speed
// - code 3 pins are push-pull, high follows signal, straps ignored
// - code 3 pins carry raw transmit enable and receive valid of ports
module ipl_ctrl
    import ipl_pkg::*;
#(
    parameter int P_STRETCH_CYCLES = IPL_STRETCH_CYC
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic [5:0]  i_pin_in,
    output logic      [5:0]  o_pin_out,
    output logic      [5:0]  o_pin_oe,
    output logic      [5:0]  o_pin_in_en,
    input  wire logic [5:0]  i_strap_led_en,
    input  wire logic [1:0]  i_strap_led_fun,
    input  wire logic [5:0]  i_strap_led_pol,
    input  wire logic [2:0]  i_tx_en,
    input  wire logic [2:0]  i_rx_dv,
    input  wire logic [1:0]  i_link_up,
    input  wire logic [1:0]  i_speed_100,
    input  wire logic [1:0]  i_full_duplex,
    input  wire logic [1:0]  i_collision,
    output logic             o_pin_event
);

    localparam int CNT_W = $clog2(P_STRETCH_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(P_STRETCH_CYCLES - 1);

    typedef struct packed {
        logic [5:0]                  data;
        logic [5:0]                  dir;
        logic [5:0]                  buf_pp;
        logic [5:0]                  irq_pol;
        logic [5:0]                  irq_sts;
        logic [5:0]                  irq_en;
        logic [5:0]                  led_en;
        logic [1:0]                  led_fun;
        logic [5:0]                  led_pol;
        ipl_phase_t [IPL_STR_N-1:0]  ph;
        logic [IPL_STR_N-1:0][CNT_W-1:0] cnt;
        logic [5:0]                  pin_out;
        logic [5:0]                  pin_oe;
        logic [5:0]                  pin_in_en;
        logic [31:0]                 rdata;
        logic                        pin_event;
    } ipl_state_t;

    ipl_state_t st_q;
    ipl_state_t st_d;

    logic [IPL_STR_N-1:0] str_ev;
    logic [IPL_STR_N-1:0] str_on;
    logic [IPL_IND_N-1:0] ind;
    logic [5:0]           rd_data_bits;
    logic [5:0]           irq_hit;

    // constant lookup of the indication shown on one led pin
    function automatic logic led_pick(input logic [1:0] fun,
                                      input int pin,
                                      input logic [IPL_IND_N-1:0] v);
        logic [4:0] code;
        code = IPL_LED_MAP[fun][pin];
        return v[code];
    endfunction

    // events that start a stretcher
    always_comb begin
        str_ev[IPL_S_TX0] = i_tx_en[0];
        str_ev[IPL_S_RX0] = i_rx_dv[0];
        for (int p = 0; p < IPL_PHY_PORTS; p++) begin
            str_ev[IPL_S_ACT+p] = i_tx_en[p+1] | i_rx_dv[p+1];
            str_ev[IPL_S_COL+p] = i_collision[p] & ~i_full_duplex[p];
        end
        for (int s = 0; s < IPL_STR_N; s++) begin
            str_on[s] = (st_q.ph[s] == IPL_PH_ON);
        end
    end

    // indication vector, all true means active
    always_comb begin
        ind = '0;
        ind[0] = str_on[IPL_S_TX0];
        ind[1] = str_on[IPL_S_RX0];
        for (int p = 0; p < IPL_PHY_PORTS; p++) begin
            // link/activity: drops only during the on phase
            ind[2+p] = i_link_up[p] & ~str_on[IPL_S_ACT+p];
            ind[4+p] = ind[2+p] & i_speed_100[p];
            ind[6+p] = ind[2+p] & ~i_speed_100[p];
            ind[8+p] = i_link_up[p] &
                       (i_full_duplex[p] | str_on[IPL_S_COL+p]);
            ind[10+p] = i_link_up[p] & i_speed_100[p];
        end
        ind[12] = i_tx_en[0];
        ind[13] = i_rx_dv[0];
        ind[14] = i_tx_en[1];
        ind[15] = i_rx_dv[1];
        ind[16] = i_tx_en[2];
        ind[17] = i_rx_dv[2];
    end

    // data read-back: live level for inputs, data bit for outputs
    assign rd_data_bits = (i_pin_in & ~st_q.dir) |
                          (st_q.data & st_q.dir);

    // level match per pin, led pins never interrupt
    assign irq_hit = ~(i_pin_in ^ st_q.irq_pol) & ~st_q.led_en;

    // next state
    always_comb begin
        logic sig;
        sig  = 1'b0;
        st_d = st_q;

        // register writes
        if (i_wr) begin
            case (i_addr)
                IPL_OFF_DATA_DIR: begin
                    st_d.data = i_wdata[IPL_LO_FIELD +: 6];
                    st_d.dir  = i_wdata[IPL_HI_FIELD +: 6];
                end
                IPL_OFF_CFG: begin
                    st_d.buf_pp  = i_wdata[IPL_LO_FIELD +: 6];
                    st_d.irq_pol = i_wdata[IPL_HI_FIELD +: 6];
                end
                IPL_OFF_IRQ: begin
                    st_d.irq_en = i_wdata[IPL_HI_FIELD +: 6];
                end
                IPL_OFF_LED_CFG: begin
                    st_d.led_en  = i_wdata[IPL_LO_FIELD +: 6];
                    st_d.led_fun = i_wdata[IPL_FUN_FIELD +: 2];
                end
                default: begin
                end
            endcase
        end

        // status: write one clears, a live level in the same cycle wins
        if (i_wr && i_addr == IPL_OFF_IRQ) begin
            st_d.irq_sts = st_q.irq_sts & ~i_wdata[IPL_LO_FIELD +: 6];
        end
        st_d.irq_sts = st_d.irq_sts | irq_hit;

        // merged request, one flop behind the status
        st_d.pin_event = |(st_q.irq_sts & st_q.irq_en);

        // stretchers: on for P_STRETCH_CYCLES cycles, then hold for the same
        for (int s = 0; s < IPL_STR_N; s++) begin
            case (st_q.ph[s])
                IPL_PH_IDLE: begin
                    if (str_ev[s]) begin
                        st_d.ph[s]  = IPL_PH_ON;
                        st_d.cnt[s] = CNT_LOAD;
                    end
                end
                IPL_PH_ON: begin
                    if (st_q.cnt[s] == '0) begin
                        st_d.ph[s]  = IPL_PH_HOLD;
                        st_d.cnt[s] = CNT_LOAD;
                    end else begin
                        st_d.cnt[s] = st_q.cnt[s] - 1'b1;
                    end
                end
                IPL_PH_HOLD: begin
                    if (st_q.cnt[s] == '0) begin
                        st_d.ph[s] = IPL_PH_IDLE;
                    end else begin
                        st_d.cnt[s] = st_q.cnt[s] - 1'b1;
                    end
                end
                default: begin
                    st_d.ph[s]  = IPL_PH_IDLE;
                    st_d.cnt[s] = '0;
                end
            endcase
        end

        // pin drivers
        for (int i = 0; i < IPL_PIN_N; i++) begin
            if (st_q.led_en[i]) begin
                sig = led_pick(st_q.led_fun, i, ind);
                st_d.pin_in_en[i] = 1'b0;
                if (st_q.led_fun == IPL_FUN_RAW) begin
                    st_d.pin_oe[i]  = 1'b1;
                    st_d.pin_out[i] = sig;
                end else begin
                    st_d.pin_oe[i]  = sig;
                    st_d.pin_out[i] = ~st_q.led_pol[i];
                end
            end else begin
                st_d.pin_in_en[i] = 1'b1;
                if (!st_q.dir[i]) begin
                    st_d.pin_oe[i]  = 1'b0;
                    st_d.pin_out[i] = 1'b0;
                end else if (st_q.buf_pp[i]) begin
                    st_d.pin_oe[i]  = 1'b1;
                    st_d.pin_out[i] = st_q.data[i];
                end else begin
                    st_d.pin_oe[i]  = ~st_q.data[i];
                    st_d.pin_out[i] = 1'b0;
                end
            end
        end

        // read data stands one cycle after the strobe only
        st_d.rdata = 32'h0000_0000;
        if (i_rd) begin
            case (i_addr)
                IPL_OFF_DATA_DIR: begin
                    st_d.rdata[IPL_LO_FIELD +: 6] = rd_data_bits;
                    st_d.rdata[IPL_HI_FIELD +: 6] = st_q.dir;
                end
                IPL_OFF_CFG: begin
                    st_d.rdata[IPL_LO_FIELD +: 6] = st_q.buf_pp;
                    st_d.rdata[IPL_HI_FIELD +: 6] = st_q.irq_pol;
                end
                IPL_OFF_IRQ: begin
                    st_d.rdata[IPL_LO_FIELD +: 6] = st_q.irq_sts;
                    st_d.rdata[IPL_HI_FIELD +: 6] = st_q.irq_en;
                end
                IPL_OFF_LED_CFG: begin
                    st_d.rdata[IPL_LO_FIELD +: 6]  = st_q.led_en;
                    st_d.rdata[IPL_FUN_FIELD +: 2] = st_q.led_fun;
                end
                IPL_OFF_SYS_IRQ: begin
                    st_d.rdata[0] = st_q.pin_event;
                end
                default: begin
                end
            endcase
        end
    end

    // state register; straps are loaded while reset is held
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            st_q           <= '0;
            st_q.data      <= IPL_RST_DATA;
            st_q.dir       <= IPL_RST_DIR;
            st_q.buf_pp    <= IPL_RST_BUF;
            st_q.irq_en    <= IPL_RST_IRQ_EN;
            st_q.irq_pol   <= IPL_RST_IRQ_POL;
            st_q.led_en    <= i_strap_led_en;
            st_q.led_fun   <= i_strap_led_fun;
            st_q.led_pol   <= i_strap_led_pol;
            st_q.pin_in_en <= 6'h3F;
            st_q.ph        <= {IPL_STR_N{IPL_PH_IDLE}};
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign o_rdata     = st_q.rdata;
    assign o_pin_out   = st_q.pin_out;
    assign o_pin_oe    = st_q.pin_oe;
    assign o_pin_in_en = st_q.pin_in_en;
    assign o_pin_event = st_q.pin_event;

endmodule // ipl_ctrl

// File: ipl_ctrl_checker.sv
// port assertions for the pin and status led block
`timescale 1ns/1ps
module ipl_ctrl_checker
    import ipl_pkg::*;
#(
    parameter int P_STRETCH_CYCLES = 8
) (
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [5:0]  o_pin_out,
    input wire logic [5:0]  o_pin_oe,
    input wire logic [5:0]  o_pin_in_en,
    input wire logic [5:0]  i_strap_led_en,
    input wire logic [1:0]  i_strap_led_fun,
    input wire logic [5:0]  i_strap_led_pol,
    input wire logic [2:0]  i_tx_en,
    input wire logic [2:0]  i_rx_dv,
    input wire logic        o_pin_event
);
    logic [5:0]  dir_q, bt_q, dat_q, led_q, pol_q, raw;
    logic [1:0]  fun_q;
    logic [31:0] cnt_q;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // raw signal each pin shows under code 3
    assign raw = {i_tx_en[0], i_tx_en[2], i_rx_dv[2],
                  i_rx_dv[0], i_tx_en[1], i_rx_dv[1]};
    // shadow of the configuration, straps taken while in reset
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            {dir_q, bt_q, dat_q} <= '0;
            {led_q, fun_q} <= {i_strap_led_en, i_strap_led_fun};
            pol_q <= i_strap_led_pol;
        end else if (i_wr && i_addr == IPL_OFF_DATA_DIR) begin
            {dir_q, dat_q} <= {i_wdata[13:8], i_wdata[5:0]};
        end else if (i_wr && i_addr == IPL_OFF_CFG) begin
            bt_q <= i_wdata[5:0];
        end else if (i_wr && i_addr == IPL_OFF_LED_CFG) begin
            {fun_q, led_q} <= {i_wdata[9:8], i_wdata[5:0]};
        end
    end
    // length of the present active run of pin 5 under code 2
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !(o_pin_oe[5] && led_q[5] && fun_q == 2'h2)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
    property p_rst; $rose(i_rst_n) |-> o_pin_oe == 6'h00; endproperty
    a_rst: assert property (p_rst) else $error("pins driven at reset");
    property p_od; $past(i_rst_n) |-> ((o_pin_oe ^ ~$past(dat_q))
        & $past(dir_q & ~bt_q & ~led_q)) == 6'h00; endproperty
    a_od: assert property (p_od) else $error("open drain wrong");
    property p_pp; $past(i_rst_n) |-> ((~o_pin_oe | (o_pin_out ^ $past(dat_q)))
        & $past(dir_q & bt_q & ~led_q)) == 6'h00; endproperty
    a_pp: assert property (p_pp) else $error("push pull wrong");
    property p_evt; $past(i_rd && i_addr == IPL_OFF_SYS_IRQ)
        |-> o_rdata == {31'h0, $past(o_pin_event)}; endproperty
    a_evt: assert property (p_evt) else $error("event mirror wrong");
    property p_inb; $past(i_rst_n) |-> o_pin_in_en == ~$past(led_q);
    endproperty
    a_inb: assert property (p_inb) else $error("input buffer wrong");
    property p_pol; $past(i_rst_n) |-> ((o_pin_out ^ ~pol_q) & o_pin_oe
        & $past(led_q & {6{fun_q != 2'h3}})) == 6'h00; endproperty
    a_pol: assert property (p_pol) else $error("led level wrong");
    property p_raw; $past(i_rst_n) |-> ((~o_pin_oe | (o_pin_out ^ $past(raw)))
        & $past(led_q & {6{fun_q == 2'h3}})) == 6'h00; endproperty
    a_raw: assert property (p_raw) else $error("raw led wrong");
    property p_len; $fell(o_pin_oe[5]) && $past(led_q[5] && fun_q == 2'h2)
        |-> cnt_q == P_STRETCH_CYCLES; endproperty
    a_len: assert property (p_len) else $error("pulse length wrong");
endmodule // ipl_ctrl_checker

bind ipl_ctrl ipl_ctrl_checker #(.P_STRETCH_CYCLES(P_STRETCH_CYCLES)) u_chk (.*);

// File: ipl_pin_model.sv
// far side of the six pins: pull-ups and an external driver
`timescale 1ns/1ps
module ipl_pin_model (
    input  wire logic [5:0] i_drv_val,
    input  wire logic [5:0] i_drv_en,
    input  wire logic [5:0] i_ext_val,
    input  wire logic [5:0] i_ext_en,
    output logic      [5:0] o_level
);
    // block drive wins, then the far end, else the pull-up holds high
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            o_level[i] = i_drv_en[i] ? i_drv_val[i] :
                (i_ext_en[i] ? i_ext_val[i] : 1'b1);
        end
    end
endmodule // ipl_pin_model

// File: ipl_pkg.sv
// constants, state codes and lookup table for the pin and status led block
package ipl_pkg;

    // pin, port and stretcher counts
    localparam int IPL_PIN_N      = 6;
    localparam int IPL_PHY_PORTS  = 2;
    localparam int IPL_STR_N      = 6;

    // register offsets on the plain register port
    localparam logic [7:0] IPL_OFF_DATA_DIR = 8'h00;
    localparam logic [7:0] IPL_OFF_CFG      = 8'h04;
    localparam logic [7:0] IPL_OFF_IRQ      = 8'h08;
    localparam logic [7:0] IPL_OFF_LED_CFG  = 8'h0C;
    localparam logic [7:0] IPL_OFF_SYS_IRQ  = 8'h10;

    // field positions inside the registers
    localparam int IPL_LO_FIELD  = 0;   // data, buffer type, irq status
    localparam int IPL_HI_FIELD  = 8;   // direction, polarity, irq enable
    localparam int IPL_FUN_FIELD = 8;   // led function code

    // values after reset
    localparam logic [5:0] IPL_RST_DIR     = 6'h00;
    localparam logic [5:0] IPL_RST_IRQ_EN  = 6'h00;
    localparam logic [5:0] IPL_RST_IRQ_POL = 6'h00;
    localparam logic [5:0] IPL_RST_DATA    = 6'h00;
    localparam logic [5:0] IPL_RST_BUF     = 6'h00;

    // led function codes
    localparam logic [1:0] IPL_FUN_RAW = 2'h3;

    // stretch timing: 80 ms at a 10 ns clock
    localparam int IPL_CLK_PERIOD_NS = 10;
    localparam int IPL_STRETCH_MS    = 80;
    localparam int IPL_STRETCH_CYC   =
        IPL_STRETCH_MS * 1000000 / IPL_CLK_PERIOD_NS;

    // pulse stretcher phases
    typedef enum logic [1:0] {
        IPL_PH_IDLE,
        IPL_PH_ON,
        IPL_PH_HOLD
    } ipl_phase_t;

    // stretcher slots: tx0, rx0, act p1, act p2, col p1, col p2
    localparam int IPL_S_TX0 = 0;
    localparam int IPL_S_RX0 = 1;
    localparam int IPL_S_ACT = 2;
    localparam int IPL_S_COL = 4;

    // indication codes, index into the indication vector
    localparam int IPL_IND_N = 18;
    localparam logic [4:0] IPL_LED_MAP [0:3][0:5] = '{
        '{5'd10, 5'd8, 5'd2, 5'd11, 5'd9, 5'd3},
        '{5'd6,  5'd8, 5'd4, 5'd7,  5'd9, 5'd5},
        '{5'd10, 5'd2, 5'd1, 5'd11, 5'd3, 5'd0},
        '{5'd15, 5'd14, 5'd13, 5'd17, 5'd16, 5'd12}
    };

endpackage

// File: test_io_pin_and_status_led_ctrl.sv
// self-checking bench for the pin and status led block
`timescale 1ns/1ps
module test_io_pin_and_status_led_ctrl;
    import ipl_pkg::*;
    localparam int P = 8;
    typedef struct packed {logic [5:0] dir, bt, dat, ext, oe, out;} ipl_row_t;
    logic        i_clock = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, o_pin_event;
    logic [7:0]  i_addr = '0;
    logic [31:0] i_wdata = '0, o_rdata, rd_v;
    logic [5:0]  i_pin_in, o_pin_out, o_pin_oe, o_pin_in_en;
    logic [5:0]  i_strap_led_en = '0, i_strap_led_pol = '0;
    logic [5:0]  ext_val = 6'h3F, ext_en = '0;
    logic [1:0]  i_strap_led_fun = '0, i_link_up = '0, i_speed_100 = '0;
    logic [1:0]  i_full_duplex = '0, i_collision = '0;
    logic [2:0]  i_tx_en = '0, i_rx_dv = '0;
    int          err_total = 0, n_compared = 0, k, j, m;
    // direction, buffer, data, far-end level, expected enable and level
    ipl_row_t rows [3] = '{'{6'h3F, 6'h3F, 6'h2A, 6'h00, 6'h3F, 6'h2A},
                           '{6'h3F, 6'h00, 6'h2A, 6'h00, 6'h15, 6'h00},
                           '{6'h0F, 6'h05, 6'h33, 6'h10, 6'h0D, 6'h01}};
    ipl_ctrl #(.P_STRETCH_CYCLES(P)) dut (.*);
    ipl_pin_model u_pins (.i_drv_val(o_pin_out), .i_drv_en(o_pin_oe),
        .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(i_pin_in));
    always #5 i_clock = ~i_clock;
    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (e !== g) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one-cycle register write and read
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 rd_v = o_rdata;
    endtask
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        foreach (rows[r]) begin
            ext_en <= ~rows[r].dir;
            ext_val <= rows[r].ext;
            wr(IPL_OFF_CFG, {26'h0, rows[r].bt});
            wr(IPL_OFF_DATA_DIR, {18'h0, rows[r].dir, 2'h0, rows[r].dat});
            rd(IPL_OFF_DATA_DIR);
            chk("data_dir", {18'h0, rows[r].dir, 2'h0, (rows[r].dat &
                rows[r].dir) | (rows[r].ext & ~rows[r].dir)}, rd_v);
            chk("pin_oe", 32'(rows[r].oe), 32'(o_pin_oe));
            chk("pin_out", 32'(rows[r].out), 32'(o_pin_out & o_pin_oe));
            $display("row %0d done", r);
        end
        ext_en <= 6'h3F;
        ext_val <= 6'h3F;
        wr(IPL_OFF_DATA_DIR, 32'h0);
        wr(IPL_OFF_CFG, 32'h0000_0200);
        wr(IPL_OFF_IRQ, 32'h0000_003F);
        ext_val <= 6'h3E;
        wr(IPL_OFF_IRQ, 32'h0000_0100);
        rd(IPL_OFF_IRQ);
        chk("irq", 32'h0000_0103, rd_v);
        chk("event", 32'h1, 32'(o_pin_event));
        rd(IPL_OFF_SYS_IRQ);
        chk("sys_irq", 32'h1, rd_v);
        ext_val <= 6'h3F;
        wr(IPL_OFF_IRQ, 32'h0000_0101);
        rd(IPL_OFF_IRQ);
        chk("irq_clr", 32'h0000_0102, rd_v);
        chk("masked", 32'h0, 32'(o_pin_event));
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20);
        chk("unmapped", 32'h0, rd_v);
        $display("gpio tests done");
        i_strap_led_en <= 6'h3F;
        i_strap_led_fun <= 2'h2;
        i_strap_led_pol <= 6'h2A;
        i_link_up <= 2'h1;
        i_speed_100 <= 2'h1;
        i_rst_n <= 1'b0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd(IPL_OFF_LED_CFG);
        chk("led_cfg", 32'h0000_023F, rd_v);
        rd(IPL_OFF_DATA_DIR);
        chk("dir", 32'h0, rd_v & 32'h0000_3F00);
        rd(IPL_OFF_CFG);
        chk("pol", 32'h0, rd_v & 32'h0000_3F00);
        rd(IPL_OFF_IRQ);
        chk("irq_en", 32'h0, rd_v & 32'h0000_3F00);
        chk("led_oe", 32'h03, 32'(o_pin_oe));
        chk("led_out", 32'h01, 32'(o_pin_out & o_pin_oe));
        chk("in_en", 32'h0, 32'(o_pin_in_en));
        i_tx_en <= 3'h3;
        i_rx_dv <= 3'h1;
        @(posedge i_clock);
        i_tx_en <= 3'h0;
        i_rx_dv <= 3'h0;
        k = 0;
        j = 0;
        m = 0;
        repeat (4 * P) begin
            @(posedge i_clock);
            #1 k += int'(o_pin_oe[5]);
            j += int'(!o_pin_oe[1]);
            m += int'(o_pin_oe[2]);
        end
        chk("tx0_run", 32'(P), 32'(k));
        chk("act_gap", 32'(P), 32'(j));
        chk("rx0_run", 32'(P), 32'(m));
        // code 0 and code 1 maps with port 1 up at 100 Mbps, full duplex
        wr(IPL_OFF_LED_CFG, 32'h0000_003F);
        i_full_duplex <= 2'h1;
        repeat (3) @(posedge i_clock);
        #1 chk("fun0_oe", 32'h07, 32'(o_pin_oe));
        wr(IPL_OFF_LED_CFG, 32'h0000_013F);
        repeat (3) @(posedge i_clock);
        #1 chk("fun1_oe", 32'h06, 32'(o_pin_oe));
        // half duplex collision gives one stretched pulse on pin 1
        i_full_duplex <= 2'h0;
        i_collision <= 2'h1;
        @(posedge i_clock);
        i_collision <= 2'h0;
        k = 0;
        repeat (4 * P) begin
            @(posedge i_clock);
            #1 k += int'(o_pin_oe[1]);
        end
        chk("col_run", 32'(P), 32'(k));
        wr(IPL_OFF_LED_CFG, 32'h0000_033F);
        i_tx_en <= 3'h1;
        i_rx_dv <= 3'h2;
        repeat (3) @(posedge i_clock);
        #1 chk("raw_oe", 32'h3F, 32'(o_pin_oe));
        chk("raw_out", 32'h21, 32'(o_pin_out));
        $display("led tests done");
        conclude();
    end
endmodule // test_io_pin_and_status_led_ctrl
